/* File: hw/reset_config_pkg.sv */
/*
  Constants for the reset and configuration controller: configuration
  word layout, register addresses, reset values, timing and state codes.
  Assumes a single 20 MHz system clock.
*/
`default_nettype none

package reset_config_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int POR_DELAY_NS  = 1_125_000;
  localparam int SUB_DELAY_NS  = 10_000;
  localparam int POR_CYCLES    =
    (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SUB_CYCLES    =
    (SUB_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 16;

  // Configuration word
  localparam int CFG_W          = 12;
  localparam int CFG_IMPL_W     = 5;
  localparam int CFG_PIN_FUNC   = 4;
  localparam int CFG_CODE_PROT  = 3;
  localparam int CFG_WDOG_EN    = 2;
  localparam int CFG_PULLUP_N   = 1;
  localparam int CFG_OSC_FREQ   = 0;

  // Register addresses on the core register port
  localparam int          ADDR_W       = 5;
  localparam logic [4:0]  ADDR_PC_LOW  = 5'h02;
  localparam logic [4:0]  ADDR_STATUS  = 5'h03;
  localparam logic [4:0]  ADDR_TRIM    = 5'h05;

  // Status bit positions and masks
  localparam int         ST_WAKE      = 7;
  localparam int         ST_TIMEOUT_N = 4;
  localparam int         ST_PDOWN_N   = 3;
  localparam logic [7:0] STATUS_WR_MASK = 8'he7;
  localparam logic [7:0] STATUS_RST_MASK = 8'h60;

  // Reset values
  localparam logic [7:0] PC_LOW_RST  = 8'hff;
  localparam logic [7:0] OPTION_RST  = 8'hff;
  localparam logic [7:0] TRIM_RST    = 8'hfe;
  localparam logic [7:0] PC_WRAP     = 8'h00;
  localparam logic [7:0] ZERO8       = 8'h00;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_CFG_LOAD,
    ST_HOLD,
    ST_TIMER,
    ST_FETCH,
    ST_LOAD_CAL,
    ST_RUN,
    ST_SLEEP
  } seq_state_t;

endpackage

`default_nettype wire

/* File: hw/reset_config_controller.sv */
/*
  Reset and configuration controller: latches the configuration word,
  sequences reset with the device reset timer, fetches the calibration
  literal from the top of program memory, classifies reset causes and
  owns program counter low, status, trim and option reset values.
  Assumes all inputs are synchronous to sys_clk; rst is the power-on
  reset; the watchdog counter runs elsewhere and reports a timeout pulse.
*/
`default_nettype none

module reset_config_controller #(
  parameter int POR_COUNT = reset_config_pkg::POR_CYCLES,
  parameter int PROG_AW   = 8
) (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic [11:0]        config_nvm,
  input  wire logic               shared_input_pin,
  input  wire logic               watchdog_timeout,
  input  wire logic               pin_change,
  input  wire logic               sleep_cmd,
  input  wire logic [4:0]         reg_addr,
  input  wire logic               reg_wr_en,
  input  wire logic [7:0]         reg_wr_data,
  input  wire logic               option_wr_en,
  input  wire logic [7:0]         option_wr_data,
  input  wire logic [11:0]        prog_rdata,
  input  wire logic [PROG_AW-1:0] ext_read_addr,
  output logic [PROG_AW-1:0]      prog_addr,
  output logic                    fetch_active,
  output logic                    core_reset,
  output logic                    sleeping,
  output logic                    work_reg_load,
  output logic [7:0]              work_reg_preset,
  output logic [7:0]              reg_rd_data,
  output logic [7:0]              pc_low,
  output logic [7:0]              option_reg,
  output logic [7:0]              oscillator_trim,
  output logic                    osc_frequency_select,
  output logic                    watchdog_enable,
  output logic                    watchdog_run,
  output logic                    reset_pin_function_select,
  output logic                    pullup_enable,
  output logic                    pin_digital_in,
  output logic                    code_protect_active,
  output logic                    ext_read_allowed
);

  ////////////////////////////////////////////////////////////////////////
  // Configuration word

  reset_config_pkg::seq_state_t state_q;
  reset_config_pkg::seq_state_t state_d;
  logic [11:0] cfg_q;
  logic        ext_reset_req;
  logic        wdog_req;
  logic        wake_req;
  logic        any_req;

  // Captured once after power-on release; a strap must not meet rst
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_q <= 12'h000;
    end else if (state_q == reset_config_pkg::ST_CFG_LOAD) begin
      cfg_q <= {{(reset_config_pkg::CFG_W -
                  reset_config_pkg::CFG_IMPL_W){1'b0}},
                config_nvm[reset_config_pkg::CFG_IMPL_W-1:0]};
    end
  end

  // Decoded controls; no register path reaches cfg_q
  assign reset_pin_function_select =
    cfg_q[reset_config_pkg::CFG_PIN_FUNC];
  assign code_protect_active = ~cfg_q[reset_config_pkg::CFG_CODE_PROT];
  assign watchdog_enable = cfg_q[reset_config_pkg::CFG_WDOG_EN];
  assign watchdog_run = watchdog_enable;
  assign pullup_enable = reset_pin_function_select &
    ~cfg_q[reset_config_pkg::CFG_PULLUP_N];
  assign osc_frequency_select = cfg_q[reset_config_pkg::CFG_OSC_FREQ];

  // Pin is reset input or plain input; reset held inactive otherwise
  assign ext_reset_req = reset_pin_function_select & ~shared_input_pin;
  assign pin_digital_in = reset_pin_function_select ? 1'b0
                                                    : shared_input_pin;

  // Top word stays readable so the calibration can be saved
  assign ext_read_allowed = ~code_protect_active |
                            (&ext_read_addr);

  ////////////////////////////////////////////////////////////////////////
  // Reset sequencer

  logic [15:0] count_q;
  logic        por_q;
  logic        live_q;

  // Only an armed watchdog may reset the part
  assign wdog_req = watchdog_enable & watchdog_timeout;
  assign wake_req = (state_q == reset_config_pkg::ST_SLEEP) & pin_change;
  assign live_q   = (state_q == reset_config_pkg::ST_RUN) |
                    (state_q == reset_config_pkg::ST_SLEEP);
  assign any_req  = live_q & (ext_reset_req | wdog_req | wake_req);

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      reset_config_pkg::ST_CFG_LOAD: state_d = reset_config_pkg::ST_HOLD;
      reset_config_pkg::ST_HOLD: begin
        if (!ext_reset_req) begin
          state_d = reset_config_pkg::ST_TIMER;
        end
      end
      reset_config_pkg::ST_TIMER: begin
        if (count_q == 16'h0000) begin
          state_d = reset_config_pkg::ST_FETCH;
        end
      end
      reset_config_pkg::ST_FETCH: state_d = reset_config_pkg::ST_LOAD_CAL;
      reset_config_pkg::ST_LOAD_CAL: state_d = reset_config_pkg::ST_RUN;
      reset_config_pkg::ST_RUN: begin
        if (any_req) begin
          state_d = reset_config_pkg::ST_HOLD;
        end else if (sleep_cmd) begin
          state_d = reset_config_pkg::ST_SLEEP;
        end
      end
      reset_config_pkg::ST_SLEEP: begin
        if (any_req) begin
          state_d = reset_config_pkg::ST_HOLD;
        end
      end
      default: state_d = reset_config_pkg::ST_CFG_LOAD;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= reset_config_pkg::ST_CFG_LOAD;
    end else begin
      state_q <= state_d;
    end
  end

  // Power-on marker picks the long timer delay
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      por_q <= 1'b1;
    end else if (state_q == reset_config_pkg::ST_LOAD_CAL) begin
      por_q <= 1'b0;
    end
  end

  // Device reset timer; restarts while the reset pin is still held
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_q <= 16'h0000;
    end else if (state_q == reset_config_pkg::ST_HOLD) begin
      count_q <= por_q ? 16'(POR_COUNT - 1)
                       : 16'(reset_config_pkg::SUB_CYCLES - 1);
    end else if (state_q == reset_config_pkg::ST_TIMER) begin
      count_q <= count_q - 16'h0001;
    end
  end

  assign core_reset   = ~live_q;
  assign sleeping     = (state_q == reset_config_pkg::ST_SLEEP);
  assign fetch_active = (state_q == reset_config_pkg::ST_FETCH) |
                        (state_q == reset_config_pkg::ST_LOAD_CAL);
  assign prog_addr    = {PROG_AW{1'b1}};

  ////////////////////////////////////////////////////////////////////////
  // Calibration fetch

  // Literal of the load instruction at the top word lands in W
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      work_reg_preset <= reset_config_pkg::ZERO8;
      work_reg_load   <= 1'b0;
    end else begin
      work_reg_load <= (state_q == reset_config_pkg::ST_LOAD_CAL);
      if (state_q == reset_config_pkg::ST_LOAD_CAL) begin
        work_reg_preset <= prog_rdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset classification and register reset values

  logic       in_sleep;
  logic       full_reset;
  logic [7:0] status_q;
  logic [7:3] flags_q;
  logic [2:0] status_lo_q;

  // Sleep flag sampled with the request decides the variant
  assign in_sleep   = (state_q == reset_config_pkg::ST_SLEEP);
  // Run resets and a pin-change wake reset registers; sleep resets by pin or watchdog do not
  assign full_reset = any_req & (~in_sleep | (~ext_reset_req &
                      ~wdog_req));

  // Program counter: all ones on every reset, then wraps to zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pc_low <= reset_config_pkg::PC_LOW_RST;
    end else if (any_req) begin
      pc_low <= reset_config_pkg::PC_LOW_RST;
    end else if (state_q == reset_config_pkg::ST_LOAD_CAL) begin
      pc_low <= reset_config_pkg::PC_WRAP;
    end else if (reg_wr_en && live_q &&
                 reg_addr == reset_config_pkg::ADDR_PC_LOW) begin
      pc_low <= reg_wr_data;
    end
  end

  // Option register, written only by its own instruction
  always_ff @(posedge sys_clk) begin
    if (rst || full_reset) begin
      option_reg <= reset_config_pkg::OPTION_RST;
    end else if (option_wr_en && live_q) begin
      option_reg <= option_wr_data;
    end
  end

  // Trim: fe on power-on only, kept through later resets
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      oscillator_trim <= reset_config_pkg::TRIM_RST;
    end else if (reg_wr_en && live_q &&
                 reg_addr == reset_config_pkg::ADDR_TRIM) begin
      oscillator_trim <= reg_wr_data;
    end
  end

  // Status low bits have no reset at all: unknown at power-on
  always_ff @(posedge sys_clk) begin
    if (reg_wr_en && live_q && !any_req &&
        reg_addr == reset_config_pkg::ADDR_STATUS) begin
      status_lo_q <= reg_wr_data[2:0];
    end
  end

  // Split halves keep one writer per flop; read back as one byte
  assign status_q = {flags_q, status_lo_q};

  // Cause flags and page bits; software cannot write the two low-true
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags_q <= 5'b00011;
    end else if (any_req) begin
      flags_q[reset_config_pkg::ST_WAKE] <= wake_req & ~ext_reset_req &
                                            ~wdog_req;
      if (full_reset) begin
        flags_q[6:5] <= reset_config_pkg::ZERO8[1:0];
      end
      if (ext_reset_req && in_sleep) begin
        flags_q[reset_config_pkg::ST_TIMEOUT_N] <= 1'b1;
        flags_q[reset_config_pkg::ST_PDOWN_N]   <= 1'b0;
      end else if (wdog_req && !ext_reset_req) begin
        flags_q[reset_config_pkg::ST_TIMEOUT_N] <= 1'b0;
        if (in_sleep) begin
          flags_q[reset_config_pkg::ST_PDOWN_N] <= 1'b0;
        end
      end else if (!ext_reset_req) begin
        flags_q[reset_config_pkg::ST_TIMEOUT_N] <= 1'b1;
        flags_q[reset_config_pkg::ST_PDOWN_N]   <= 1'b0;
      end
    end else if (state_q == reset_config_pkg::ST_RUN && sleep_cmd) begin
      flags_q[reset_config_pkg::ST_TIMEOUT_N] <= 1'b1;
      flags_q[reset_config_pkg::ST_PDOWN_N]   <= 1'b0;
    end else if (reg_wr_en && live_q &&
                 reg_addr == reset_config_pkg::ADDR_STATUS) begin
      flags_q[7:5] <= reg_wr_data[7:5] &
                      reset_config_pkg::STATUS_WR_MASK[7:5];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read port, one cycle latency

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rd_data <= reset_config_pkg::ZERO8;
    end else begin
      case (reg_addr)
        reset_config_pkg::ADDR_PC_LOW: reg_rd_data <= pc_low;
        reset_config_pkg::ADDR_STATUS: reg_rd_data <= status_q;
        reset_config_pkg::ADDR_TRIM:   reg_rd_data <= oscillator_trim;
        default:                       reg_rd_data <= reset_config_pkg::ZERO8;
      endcase
    end
  end

endmodule

`default_nettype wire

/* File: tb/reset_config_controller_sva.sv */
/*
  Concurrent checks on the reset and configuration controller ports.
  Assumes it is bound to the controller and sees its ports by name.
*/
`default_nettype none

module reset_config_controller_sva #(
  parameter int PROG_AW = 8
) (
  input wire logic               sys_clk,
  input wire logic               rst,
  input wire logic               shared_input_pin,
  input wire logic               watchdog_timeout,
  input wire logic [4:0]         reg_addr,
  input wire logic               reg_wr_en,
  input wire logic [7:0]         reg_wr_data,
  input wire logic [PROG_AW-1:0] ext_read_addr,
  input wire logic [PROG_AW-1:0] prog_addr,
  input wire logic               fetch_active,
  input wire logic               core_reset,
  input wire logic               sleeping,
  input wire logic               work_reg_load,
  input wire logic [7:0]         pc_low,
  input wire logic [7:0]         option_reg,
  input wire logic [7:0]         oscillator_trim,
  input wire logic               watchdog_enable,
  input wire logic               reset_pin_function_select,
  input wire logic               pullup_enable,
  input wire logic               pin_digital_in,
  input wire logic               code_protect_active,
  input wire logic               ext_read_allowed
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [15:0] hold_q;
  logic        first_q;
  logic        pin_rst;

  //////////////////////////////////////////////////////////////////////////
  // Reset length counter; first sequence after rst is the long one
  assign pin_rst = reset_pin_function_select && !shared_input_pin;
  always_ff @(posedge sys_clk) begin
    hold_q <= (rst || !core_reset) ? 16'h0 : hold_q + 16'h1;
  end
  always_ff @(posedge sys_clk) begin
    first_q <= rst ? 1'b1 : (core_reset ? first_q : 1'b0);
  end

  //////////////////////////////////////////////////////////////////////////
  a_pin_func_gate: assert property (reset_pin_function_select |->
    !pin_digital_in) else $error("pin input seen in reset mode");
  a_pullup_gate: assert property (pullup_enable |->
    reset_pin_function_select) else $error("pull-up outside reset mode");
  a_unprot_read: assert property (!code_protect_active |->
    ext_read_allowed) else $error("read blocked with protection off");
  a_top_readable: assert property (&ext_read_addr |->
    ext_read_allowed) else $error("top word not readable");
  a_fetch_top: assert property ($fell(core_reset) |->
    $past(fetch_active) && &prog_addr)
    else $error("fetch not from top address");
  a_wrap_load: assert property ($fell(core_reset) |->
    work_reg_load && pc_low == 8'h00) else $error("no wrap or load");
  a_ext_run_rst: assert property (!core_reset && !sleeping && pin_rst
    |=> core_reset) else $error("pin reset not taken");
  a_wdog_off: assert property (!core_reset && !sleeping
    && !watchdog_enable && watchdog_timeout && !pin_rst |=> !core_reset)
    else $error("reset without enabled cause");
  a_trim_write: assert property (reg_wr_en && reg_addr == 5'h05
    && !core_reset |=> oscillator_trim == $past(reg_wr_data))
    else $error("trim write lost");
  a_por_values: assert property (disable iff (1'b0) rst |=>
    pc_low == 8'hff && option_reg == 8'hff && oscillator_trim == 8'hfe)
    else $error("power-on values wrong");
  a_short_timer: assert property ($fell(core_reset) && !first_q |->
    hold_q >= 16'd200) else $error("reset timer too short");
endmodule

`default_nettype wire

/* File: tb/reset_far_side_model.sv */
/*
  Far side of the controller: reset pin, watchdog, pin-change source
  and program memory holding the calibration literal at the top word.
  Assumes the bench calls its tasks; all changes follow a rising edge.
*/
`default_nettype none

module reset_far_side_model #(
  parameter int         PROG_AW = 8,
  parameter logic [7:0] CAL     = 8'h9c  // Arbitrary calibration value
) (
  input  wire logic               sys_clk,
  input  wire logic [PROG_AW-1:0] prog_addr,
  output logic                    shared_input_pin,
  output logic                    watchdog_timeout,
  output logic                    pin_change,
  output logic [11:0]             prog_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    shared_input_pin = 1'b1;  // Pull-up holds the pin high when idle
    watchdog_timeout = 1'b0;
    pin_change = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Top word is the load-literal; elsewhere a pattern, never a copy
  assign prog_rdata = (&prog_addr) ? {4'hc, CAL}
                                   : 12'ha5a ^ 12'(prog_addr);

  // Pin pulled low for n cycles, then released to the pull-up
  task automatic pin_low(input int n);
    @(posedge sys_clk) shared_input_pin <= 1'b0;
    repeat (n) @(posedge sys_clk);
    shared_input_pin <= 1'b1;
  endtask

  // Timeout from the watchdog's own oscillator, one cycle wide
  task automatic wdog_pulse();
    @(posedge sys_clk) watchdog_timeout <= 1'b1;
    @(posedge sys_clk) watchdog_timeout <= 1'b0;
  endtask

  task automatic change_pulse();
    @(posedge sys_clk) pin_change <= 1'b1;
    @(posedge sys_clk) pin_change <= 1'b0;
  endtask
endmodule

`default_nettype wire

/* File: tb/reset_config_controller_tb.sv */
/*
  Self-checking bench: power-on with two configuration words, register
  access, and every reset kind with the resulting cause flags.
  Assumes the far-side model supplies pin, watchdog and program memory.
*/
`default_nettype none

module reset_config_controller_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] cfg = 12'h01a;
  logic        sleep_cmd = 1'b0;
  logic [4:0]  reg_addr = 5'h00;
  logic        reg_wr_en = 1'b0;
  logic [7:0]  reg_wr_data = 8'h00;
  logic        option_wr_en = 1'b0;
  logic [7:0]  option_wr_data = 8'h00;
  logic [7:0]  ext_read_addr = 8'h00;
  logic [7:0]  prog_addr, rd_q, option_reg, trim, pc_low, preset;
  logic [11:0] prog_rdata;
  logic        pin, wdog, pchg, core_reset, sleeping, wload, digin;
  logic        pfs, cpa, wde, pue, ofs, allowed, fetch, wrun;
  int          n_mismatch = 0;
  int          num_checks = 0;

  always #25 sys_clk = ~sys_clk;

  reset_config_controller #(.POR_COUNT(20), .PROG_AW(8)) dut_u (
    .sys_clk, .rst, .config_nvm(cfg), .shared_input_pin(pin),
    .watchdog_timeout(wdog), .pin_change(pchg), .sleep_cmd, .reg_addr,
    .reg_wr_en, .reg_wr_data, .option_wr_en, .option_wr_data, .prog_rdata,
    .ext_read_addr, .prog_addr, .fetch_active(fetch), .core_reset, .sleeping,
    .work_reg_load(wload), .work_reg_preset(preset), .reg_rd_data(rd_q),
    .pc_low, .option_reg, .oscillator_trim(trim),
    .osc_frequency_select(ofs), .watchdog_enable(wde), .watchdog_run(wrun),
    .reset_pin_function_select(pfs), .pullup_enable(pue),
    .pin_digital_in(digin), .code_protect_active(cpa),
    .ext_read_allowed(allowed));

  reset_far_side_model #(.PROG_AW(8)) far_u (.sys_clk, .prog_addr,
    .shared_input_pin(pin), .watchdog_timeout(wdog), .pin_change(pchg),
    .prog_rdata);

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge sys_clk) reg_addr <= a;
    @(posedge sys_clk) #1 d = rd_q;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk) reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge sys_clk) reg_wr_en <= 1'b0;
  endtask

  task automatic flags(input logic [2:0] e);
    logic [7:0] d;
    rd(5'h03, d);
    chk("cause flags", {5'h0, e}, {5'h0, d[7], d[4], d[3]});
  endtask

  task automatic wait_run();
    // A request may be taken as late as the edge the caller ends on
    @(posedge sys_clk) #1;
    chk("in reset", 8'h01, {7'h0, core_reset});
    for (int i = 0; i < 600 && core_reset !== 1'b0; i++)
      @(posedge sys_clk) #1;
    chk("fetch done", 8'h00, {7'h0, fetch});
    chk("load pulse", 8'h01, {7'h0, wload});
    chk("preset", far_u.CAL, preset);
    chk("pc wrap", 8'h00, pc_low);
  endtask

  task automatic sleep();
    @(posedge sys_clk) sleep_cmd <= 1'b1;
    @(posedge sys_clk) sleep_cmd <= 1'b0;
    #1 chk("sleeping", 8'h01, {7'h0, sleeping});
  endtask

  task automatic por(input logic [11:0] c, input logic [4:0] e);
    logic [7:0] d;
    @(posedge sys_clk) rst <= 1'b1;
    cfg <= c;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    wait_run();
    chk("cfg", {3'h0, e}, {3'h0, pfs, cpa, wde, pue, ofs});
    chk("wdog run", {7'h0, e[2]}, {7'h0, wrun});
    flags(3'b011);
    rd(5'h05, d);
    chk("trim", 8'hfe, d);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Timeout guard, about four times the expected run
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    logic [7:0] d;
    por(12'hf18, 5'b10010);
    wr(5'h05, 8'h5a);
    rd(5'h05, d);
    chk("trim", 8'h5a, d);
    rd(5'h1f, d);
    chk("unmapped", 8'h00, d);
    far_u.wdog_pulse();
    far_u.change_pulse();
    @(posedge sys_clk) #1 chk("running", 8'h00, {7'h0, core_reset});
    far_u.pin_low(3);
    wait_run();
    flags(3'b011);
    sleep();
    far_u.change_pulse();
    wait_run();
    flags(3'b110);
    sleep();
    far_u.pin_low(3);
    wait_run();
    flags(3'b010);
    rd(5'h05, d);
    chk("trim kept", 8'h5a, d);
    por(12'h005, 5'b01101);
    chk("prot read", 8'h00, {7'h0, allowed});
    @(posedge sys_clk) ext_read_addr <= 8'hff;
    @(posedge sys_clk) #1 chk("top read", 8'h01, {7'h0, allowed});
    chk("cal saved", far_u.CAL, prog_rdata[7:0]);
    // Pin looked at while low and again once released
    fork
      far_u.pin_low(2);
      @(posedge sys_clk) #1 chk("pin low", 8'h00, {6'h0, core_reset, digin});
    join
    #1 chk("pin high", 8'h01, {6'h0, core_reset, digin});
    far_u.wdog_pulse();
    wait_run();
    flags(3'b001);
    @(posedge sys_clk) option_wr_en <= 1'b1;
    option_wr_data <= 8'h3c;
    @(posedge sys_clk) option_wr_en <= 1'b0;
    sleep();
    far_u.wdog_pulse();
    wait_run();
    flags(3'b000);
    chk("option kept", 8'h3c, option_reg);
    print_verdict();
  end
endmodule

// Checker sees only the controller's ports
bind reset_config_controller reset_config_controller_sva
  #(.PROG_AW(PROG_AW)) chk_u (.sys_clk, .rst, .shared_input_pin,
  .watchdog_timeout, .reg_addr, .reg_wr_en, .reg_wr_data, .ext_read_addr,
  .prog_addr, .fetch_active, .core_reset, .sleeping, .work_reg_load,
  .pc_low, .option_reg, .oscillator_trim, .watchdog_enable,
  .reset_pin_function_select, .pullup_enable, .pin_digital_in,
  .code_protect_active, .ext_read_allowed);

`default_nettype wire
